// ===== mis_pkg.sv
/*
 * Constants, types and register map of the MAC interface selector.
 * Assumes a 40 MHz system clock and word-indexed registers on the bus.
 */
`default_nettype none
package mis_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned GIG_CLK_HZ = 125_000_000;
    localparam int unsigned FAST_CLK_HZ = 25_000_000;
    localparam int unsigned TEN_CLK_HZ = 2_500_000;
    localparam int unsigned GIG_HALF_RAW = CLK_HZ / (2 * GIG_CLK_HZ);
    localparam int unsigned FAST_HALF_RAW = CLK_HZ / (2 * FAST_CLK_HZ);
    localparam int unsigned TEN_HALF_RAW = CLK_HZ / (2 * TEN_CLK_HZ);
    localparam logic [7:0] GIG_HALF = (GIG_HALF_RAW < 1) ? 8'h01 : 8'(GIG_HALF_RAW);
    localparam logic [7:0] FAST_HALF = (FAST_HALF_RAW < 1) ? 8'h01 : 8'(FAST_HALF_RAW);
    localparam logic [7:0] TEN_HALF = (TEN_HALF_RAW < 1) ? 8'h01 : 8'(TEN_HALF_RAW);
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    // ****************************************
    // Register indices (byte address = 4 x index)
    // ****************************************
    localparam logic [5:0] IDX_PHY_CONTROL = 6'h10;
    localparam logic [5:0] IDX_STATUS = 6'h11;
    localparam logic [5:0] IDX_SECOND_CONFIG = 6'h14;
    localparam logic [5:0] IDX_PARALLEL_CONTROL = 6'h32;
    localparam logic [5:0] IDX_STRAP_STATUS = 6'h33;
    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int unsigned SER_EN_BIT = 11;
    localparam int unsigned LOOPBACK_BIT = 14;
    localparam int unsigned NEG_EN_BIT = 0;
    localparam int unsigned SIX_WIRE_BIT = 1;
    localparam int unsigned ADAPT_BIT = 7;
    localparam int unsigned PAR_EN_BIT = 7;
    localparam int unsigned STRAP_SER_BIT = 0;
    localparam int unsigned STRAP_PAR_DIS_BIT = 1;
    localparam int unsigned STS_MODE_LSB = 0;
    localparam int unsigned STS_SPEED_LSB = 2;
    localparam int unsigned STS_AN_DONE_BIT = 4;
    localparam logic [15:0] PHY_CONTROL_RST = 16'h0000;
    localparam logic [15:0] SECOND_CONFIG_RST = 16'h0001;
    localparam logic [15:0] PARALLEL_CONTROL_RST = 16'h0000;
    // ****************************************
    // Stream and in-band word
    // ****************************************
    localparam logic [7:0] SFD_BYTE = 8'hD5;
    localparam logic [6:0] REP_GIG = 7'h01;
    localparam logic [6:0] REP_FAST = 7'h0A;
    localparam logic [6:0] REP_TEN = 7'h64;
    localparam int unsigned CFG_LINK_BIT = 15;
    localparam int unsigned CFG_ACK_BIT = 14;
    localparam int unsigned CFG_SPD_LSB = 10;
    localparam int unsigned CFG_SERIAL_BIT = 0;

    typedef enum logic [1:0] {SPD_10 = 2'h0, SPD_100 = 2'h1, SPD_1000 = 2'h2} mis_speed_e;
    typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_SERIAL = 2'h1, MODE_PARALLEL = 2'h2} mis_mode_e;
    typedef enum logic [1:0] {AN_IDLE = 2'h0, AN_SEND = 2'h1, AN_DONE = 2'h3} mis_an_e;
    typedef struct packed {
        logic valid;
        logic err;
        logic [7:0] data;
    } mis_byte_s;
endpackage
`default_nettype wire

// ===== mis_mac_if_select.sv
/*
 * MAC interface selector: chooses serial or parallel MAC link, moves frame
 * bytes between the media side and the MAC, negotiates serial speed in band.
 * Assumes media stream, serial stream and bus on clk; straps and parallel
 * link pins arrive asynchronously.
 */
// Overview of operation
// - Serial enable wins; parallel only when serial off and parallel on.
// - Serial enable bit is loaded from the sampled serial strap pin.
// - Sampled serial and parallel-disable straps stay readable in strap status.
// - Serial link carries 1.25 Gbps differential data between device and MAC.
// - Transmit timing comes from incoming serial data, no MAC transmit clock.
// - Four-wire serial by default; six-wire adds a receive clock pair.
// - For MACs without clock recovery, drive a serial receive clock.
// - At 100 Mbps serial, each frame byte is repeated ten times.
// - Start-of-frame delimiter is sent once, never replicated.
// - In-band negotiation makes serial speed follow the media resolved speed.
// - In MAC loopback serial speed follows media speed selection in both modes.
// - Serial negotiation is on after reset until software disables it.
// - Clearing negotiation enable stops it and forces media resolved speed.
// - Forced serial speed works with negotiated or manual media speed.
// - At 10 Mbps serial rate adapts automatically, adapt bit untouched.
// - Parallel data and control use both rising and falling clock edges.
// - Parallel clocks run 2.5 MHz at 10 Mbps; 100 and 1000 Mbps give 20 MHz, not 25 or 125 MHz.
// - Gigabit parallel: low nibble on rising edge, high nibble on falling.
// - Control carries valid on rising edge, valid xor error on falling.
// - At 10/100 the nibble repeats on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module mis_mac_if_select (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Straps
    input wire logic serial_enable_strap_pin,
    input wire logic parallel_disable_strap_pin,
    // Media side
    input wire logic [1:0] media_speed,
    input wire logic media_link,
    input wire mis_pkg::mis_byte_s media_rx,
    output logic media_rx_ready,
    output mis_pkg::mis_byte_s media_tx,
    // Serial MAC link
    input wire mis_pkg::mis_byte_s ser_rx_in,
    output mis_pkg::mis_byte_s ser_tx,
    output logic [15:0] ser_cfg_word,
    output logic ser_cfg_valid,
    input wire logic ser_cfg_ack,
    output logic ser_rxclk_out,
    // Parallel MAC link
    input wire logic par_txclk,
    input wire logic [3:0] par_txd,
    input wire logic par_txctl,
    output logic par_rxclk,
    output logic [3:0] par_rxd,
    output logic par_rxctl
);
    // ****************************************
    // Register bus slave
    // ****************************************
    logic ack_reg, req, wr_go;
    logic [5:0] idx;
    logic [31:0] readdata_reg;
    logic [15:0] phy_control_reg, second_config_reg, parallel_if_control_reg, status_word;
    logic [1:0] strap_status_one;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    assign idx = avs_address[7:2];
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_reg;
    assign wr_go = avs_write & ack_reg;
    assign avs_readdata = readdata_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            readdata_reg <= 32'h00000000;
        end else if (avs_read && !ack_reg) begin
            unique case (idx)
                mis_pkg::IDX_PHY_CONTROL: readdata_reg <= {16'h0000, phy_control_reg};
                mis_pkg::IDX_STATUS: readdata_reg <= {16'h0000, status_word};
                mis_pkg::IDX_SECOND_CONFIG: readdata_reg <= {16'h0000, second_config_reg};
                mis_pkg::IDX_PARALLEL_CONTROL: readdata_reg <= {16'h0000, parallel_if_control_reg};
                mis_pkg::IDX_STRAP_STATUS: readdata_reg <= {30'h00000000, strap_status_one};
                default: readdata_reg <= 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // Strap sampling
    // ****************************************
    logic [1:0] strap_meta_reg, strap_sync_reg, strap_cnt_reg;
    logic strap_load;

    always_ff @(posedge clk) begin
        strap_meta_reg <= {parallel_disable_strap_pin, serial_enable_strap_pin};
        strap_sync_reg <= strap_meta_reg;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            strap_cnt_reg <= 2'h0;
        end else if (strap_cnt_reg != mis_pkg::STRAP_WAIT) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
        end
    end

    assign strap_load = (strap_cnt_reg == mis_pkg::STRAP_WAIT - 2'h1);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            strap_status_one <= 2'h0;
        end else if (strap_load) begin
            strap_status_one <= strap_sync_reg;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            phy_control_reg <= mis_pkg::PHY_CONTROL_RST;
        end else if (strap_load) begin
            phy_control_reg[mis_pkg::SER_EN_BIT] <= strap_sync_reg[mis_pkg::STRAP_SER_BIT];
        end else if (wr_go && idx == mis_pkg::IDX_PHY_CONTROL) begin
            phy_control_reg <= merge16(phy_control_reg, avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            second_config_reg <= mis_pkg::SECOND_CONFIG_RST;
        end else if (wr_go && idx == mis_pkg::IDX_SECOND_CONFIG) begin
            second_config_reg <= merge16(second_config_reg, avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            parallel_if_control_reg <= mis_pkg::PARALLEL_CONTROL_RST;
        end else if (strap_load) begin
            parallel_if_control_reg[mis_pkg::PAR_EN_BIT] <=
                ~strap_sync_reg[mis_pkg::STRAP_PAR_DIS_BIT];
        end else if (wr_go && idx == mis_pkg::IDX_PARALLEL_CONTROL) begin
            parallel_if_control_reg <= merge16(parallel_if_control_reg, avs_writedata,
                                               avs_byteenable);
        end
    end

    // ****************************************
    // Mode and serial speed
    // ****************************************
    mis_pkg::mis_mode_e mode;
    mis_pkg::mis_an_e an_state_reg;
    mis_pkg::mis_speed_e an_speed_reg, ser_speed, par_speed;
    logic serial_negotiation_enable, loopback, six_wire, ser_live;
    logic [6:0] ser_rep;

    assign serial_negotiation_enable = second_config_reg[mis_pkg::NEG_EN_BIT];
    assign loopback = phy_control_reg[mis_pkg::LOOPBACK_BIT];
    assign six_wire = second_config_reg[mis_pkg::SIX_WIRE_BIT];
    assign par_speed = mis_pkg::mis_speed_e'(media_speed);

    always_comb begin
        if (phy_control_reg[mis_pkg::SER_EN_BIT]) begin
            mode = mis_pkg::MODE_SERIAL;
        end else if (parallel_if_control_reg[mis_pkg::PAR_EN_BIT]) begin
            mode = mis_pkg::MODE_PARALLEL;
        end else begin
            mode = mis_pkg::MODE_OFF;
        end
    end

    // Forced or loopback speed tracks media side; else the negotiated one
    assign ser_speed = (loopback || !serial_negotiation_enable) ? par_speed : an_speed_reg;
    assign ser_live = (mode == mis_pkg::MODE_SERIAL) &&
                      (!serial_negotiation_enable || an_state_reg == mis_pkg::AN_DONE);

    // Ten meg adapts by a deeper replication; the adapt bit is only stored
    always_comb begin
        unique case (ser_speed)
            mis_pkg::SPD_10: ser_rep = mis_pkg::REP_TEN;
            mis_pkg::SPD_100: ser_rep = mis_pkg::REP_FAST;
            default: ser_rep = mis_pkg::REP_GIG;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            an_state_reg <= mis_pkg::AN_IDLE;
            an_speed_reg <= mis_pkg::SPD_1000;
        end else if (mode != mis_pkg::MODE_SERIAL || !serial_negotiation_enable || !media_link) begin
            an_state_reg <= mis_pkg::AN_IDLE;
        end else begin
            unique case (an_state_reg)
                mis_pkg::AN_IDLE: an_state_reg <= mis_pkg::AN_SEND;
                mis_pkg::AN_SEND: begin
                    if (ser_cfg_ack) begin
                        an_state_reg <= mis_pkg::AN_DONE;
                        an_speed_reg <= par_speed;
                    end
                end
                mis_pkg::AN_DONE: begin
                    if (par_speed != an_speed_reg) begin
                        an_state_reg <= mis_pkg::AN_IDLE;
                    end
                end
                default: an_state_reg <= mis_pkg::AN_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ser_cfg_word <= 16'h0000;
            ser_cfg_valid <= 1'b0;
        end else begin
            ser_cfg_valid <= (an_state_reg == mis_pkg::AN_SEND);
            ser_cfg_word <= 16'h0000;
            ser_cfg_word[mis_pkg::CFG_LINK_BIT] <= media_link;
            ser_cfg_word[mis_pkg::CFG_ACK_BIT] <= ser_cfg_ack;
            ser_cfg_word[mis_pkg::CFG_SPD_LSB +: 2] <= media_speed;
            ser_cfg_word[mis_pkg::CFG_SERIAL_BIT] <= 1'b1;
        end
    end

    always_comb begin
        status_word = 16'h0000;
        status_word[mis_pkg::STS_MODE_LSB +: 2] = mode;
        status_word[mis_pkg::STS_SPEED_LSB +: 2] = ser_speed;
        status_word[mis_pkg::STS_AN_DONE_BIT] = (an_state_reg == mis_pkg::AN_DONE);
    end

    // ****************************************
    // Serial path towards the MAC
    // ****************************************
    logic [6:0] rep_left_reg;
    logic [7:0] rep_byte_reg;
    logic ser_ready, par_ready, ser_clk_reg;

    assign ser_ready = ser_live && rep_left_reg == 7'h00;

    always_ff @(posedge clk) begin
        if (!resetn || !ser_live) begin
            rep_left_reg <= 7'h00;
            rep_byte_reg <= 8'h00;
            ser_tx <= '0;
        end else if (rep_left_reg != 7'h00) begin
            rep_left_reg <= rep_left_reg - 7'h01;
            ser_tx <= '{valid: 1'b1, err: 1'b0, data: rep_byte_reg};
        end else begin
            ser_tx <= media_rx;
            rep_byte_reg <= media_rx.data;
            if (media_rx.valid && media_rx.data != mis_pkg::SFD_BYTE) begin
                rep_left_reg <= ser_rep - 7'h01;
            end
        end
    end

    // Six-wire receive clock: toggles every clk, one period per two byte slots
    always_ff @(posedge clk) begin
        if (!resetn || !(six_wire && mode == mis_pkg::MODE_SERIAL)) begin
            ser_clk_reg <= 1'b0;
        end else begin
            ser_clk_reg <= ~ser_clk_reg;
        end
    end
    assign ser_rxclk_out = ser_clk_reg;

    // ****************************************
    // Parallel path towards the MAC
    // ****************************************
    logic [7:0] half_reg, half_cnt_reg, par_byte_reg;
    logic par_on, toggle, rise_evt, fall_evt, par_gig, rx_hi_reg, par_valid_reg, par_err_reg;

    assign par_on = (mode == mis_pkg::MODE_PARALLEL);
    assign par_gig = (par_speed == mis_pkg::SPD_1000);
    assign toggle = par_on && half_cnt_reg + 8'h01 >= half_reg;
    assign rise_evt = toggle && !par_rxclk;
    assign fall_evt = toggle && par_rxclk;
    assign par_ready = rise_evt && (par_gig || !rx_hi_reg);
    assign media_rx_ready = ser_ready || par_ready;

    always_comb begin
        unique case (par_speed)
            mis_pkg::SPD_10: half_reg = mis_pkg::TEN_HALF;
            mis_pkg::SPD_100: half_reg = mis_pkg::FAST_HALF;
            default: half_reg = mis_pkg::GIG_HALF;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn || !par_on) begin
            half_cnt_reg <= 8'h00;
            par_rxclk <= 1'b0;
        end else if (toggle) begin
            half_cnt_reg <= 8'h00;
            par_rxclk <= ~par_rxclk;
        end else begin
            half_cnt_reg <= half_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !par_on) begin
            rx_hi_reg <= 1'b0;
            par_byte_reg <= 8'h00;
            par_valid_reg <= 1'b0;
            par_err_reg <= 1'b0;
            par_rxd <= 4'h0;
            par_rxctl <= 1'b0;
        end else if (par_ready) begin
            par_byte_reg <= media_rx.data;
            par_valid_reg <= media_rx.valid;
            par_err_reg <= media_rx.err;
            par_rxd <= media_rx.data[3:0];
            par_rxctl <= media_rx.valid;
            rx_hi_reg <= !par_gig && media_rx.valid;
        end else if (rise_evt) begin
            par_rxd <= par_byte_reg[7:4];
            par_rxctl <= par_valid_reg;
            rx_hi_reg <= 1'b0;
        end else if (fall_evt) begin
            if (par_gig) begin
                par_rxd <= par_byte_reg[7:4];
            end
            par_rxctl <= par_valid_reg ^ par_err_reg;
        end
    end

    // ****************************************
    // Paths from the MAC to the media side
    // ****************************************
    logic [5:0] pin_meta_reg, pin_sync_reg;
    logic [6:0] derep_left_reg;
    logic tclk_prev_reg, t_rise, t_fall, tx_valid_reg, tx_nib_hi_reg;
    logic [3:0] lo_nib_reg;

    always_ff @(posedge clk) begin
        pin_meta_reg <= {par_txclk, par_txctl, par_txd};
        pin_sync_reg <= pin_meta_reg;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            tclk_prev_reg <= 1'b0;
        end else begin
            tclk_prev_reg <= pin_sync_reg[5];
        end
    end

    // Edges only count while the parallel link is the selected mode
    assign t_rise = par_on && pin_sync_reg[5] && !tclk_prev_reg;
    assign t_fall = par_on && !pin_sync_reg[5] && tclk_prev_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            derep_left_reg <= 7'h00;
            lo_nib_reg <= 4'h0;
            tx_valid_reg <= 1'b0;
            tx_nib_hi_reg <= 1'b0;
            media_tx <= '0;
        end else begin
            media_tx <= '0;
            if (ser_live) begin
                if (!ser_rx_in.valid) begin
                    derep_left_reg <= 7'h00;
                end else if (derep_left_reg == 7'h00 || ser_rx_in.data == mis_pkg::SFD_BYTE) begin
                    media_tx <= ser_rx_in;
                    derep_left_reg <= (ser_rx_in.data == mis_pkg::SFD_BYTE) ? 7'h00 : ser_rep - 7'h01;
                end else begin
                    derep_left_reg <= derep_left_reg - 7'h01;
                end
            end else if (t_rise) begin
                tx_valid_reg <= pin_sync_reg[4];
                if (par_gig || !tx_nib_hi_reg) begin
                    lo_nib_reg <= pin_sync_reg[3:0];
                    tx_nib_hi_reg <= !par_gig && pin_sync_reg[4];
                end else begin
                    media_tx <= '{valid: pin_sync_reg[4], err: 1'b0,
                                  data: {pin_sync_reg[3:0], lo_nib_reg}};
                    tx_nib_hi_reg <= 1'b0;
                end
            end else if (t_fall && par_gig && tx_valid_reg) begin
                media_tx <= '{valid: 1'b1, err: pin_sync_reg[4] ^ tx_valid_reg,
                              data: {pin_sync_reg[3:0], lo_nib_reg}};
            end
        end
    end
endmodule // mis_mac_if_select
`default_nettype wire

// ===== mis_mac_if_select_asserts.sv
/* Port assertions of the MAC interface selector.
   Assumes one clock domain and a bind from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module mis_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Watched ports
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [1:0] media_speed,
    input wire mis_pkg::mis_byte_s media_rx,
    input wire logic media_rx_ready,
    input wire mis_pkg::mis_byte_s ser_tx,
    input wire logic [15:0] ser_cfg_word,
    input wire logic ser_cfg_valid,
    input wire logic ser_cfg_ack,
    input wire logic ser_rxclk_out,
    input wire logic par_rxclk
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_take;
        media_rx.valid && media_rx_ready;
    endsequence
    sequence s_fast;
        s_take ##0 (media_speed == 2'h1 && media_rx.data != mis_pkg::SFD_BYTE) ##1 ser_tx.valid;
    endsequence
    a_bus_wait:
        assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait state");
    a_fast_rep:
        assert property (s_fast |-> !media_rx_ready [*8]) else $error("byte repeat too short");
    a_sfd_once:
        assert property (s_take ##1 (ser_tx.valid && ser_tx.data == mis_pkg::SFD_BYTE)
            |-> media_rx_ready) else $error("delimiter repeated");
    a_tx_next:
        assert property (s_take |=> !ser_tx.valid || ser_tx.data == $past(media_rx.data))
        else $error("serial byte differs from media byte");
    a_cfg_done:
        assert property (ser_cfg_valid && ser_cfg_ack |-> ##2 !ser_cfg_valid)
        else $error("config word kept after acknowledge");
    a_cfg_word:
        assert property (ser_cfg_valid |-> ser_cfg_word[mis_pkg::CFG_SERIAL_BIT] &&
            ser_cfg_word[mis_pkg::CFG_SPD_LSB +: 2] == $past(media_speed))
        else $error("config word lacks serial bit");
    a_rx_toggle:
        assert property (ser_rxclk_out |=> !ser_rxclk_out) else $error("receive clock stuck");
    a_one_mode:
        assert property (!(par_rxclk && (ser_rxclk_out || ser_tx.valid)))
        else $error("both interfaces active");
endmodule // mis_chk
`default_nettype wire

// ===== mis_mac_model.sv
/* MAC partner: acknowledges the in-band word, drives parallel transmit pins.
   Assumes the selector's clk; transmit clock period is 8 clk (200 ns). */
`timescale 1ns/1ps
`default_nettype none
module mis_mac_model #(parameter int ACK_DELAY = 2) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial side
    input wire logic ser_cfg_valid,
    output logic ser_cfg_ack,
    output mis_pkg::mis_byte_s ser_rx,
    input wire mis_pkg::mis_byte_s ser_tx,
    // Parallel side
    input wire logic par_go,
    output logic par_txclk,
    output logic [3:0] par_txd,
    output logic par_txctl
);
    int wait_cnt, div_cnt;
    assign ser_rx = ser_tx;
    always @(posedge clk) begin
        wait_cnt <= ser_cfg_valid ? wait_cnt + 1 : 0;
        ser_cfg_ack <= ser_cfg_valid && wait_cnt >= ACK_DELAY;
    end
    always @(posedge clk) begin
        div_cnt <= (div_cnt == 3) ? 0 : div_cnt + 1;
        if (!resetn || !par_go) begin
            div_cnt <= 0;
            par_txclk <= 1'b0;
            par_txctl <= 1'b0;
            par_txd <= 4'hA;
        end else if (div_cnt == 1) begin
            par_txd <= par_txd + 4'h1;
            par_txctl <= 1'b1;
        end else if (div_cnt == 3) begin
            par_txclk <= !par_txclk;
        end
    end
endmodule // mis_mac_model
`default_nettype wire

// ===== mis_mac_if_select_bench.sv
/* Self-checking bench of the MAC interface selector.
   Assumes strap serial on, parallel not disabled; MAC model on the far side. */
`timescale 1ns/1ps
`default_nettype none
module mis_mac_if_select_bench;
    logic clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, par_go = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [1:0] media_speed = 2'h1;
    logic media_link = 1'b1;
    mis_pkg::mis_byte_s media_rx = '0, media_tx, ser_rx_in, ser_tx;
    logic avs_waitrequest, media_rx_ready, ser_cfg_valid, ser_cfg_ack, ser_rxclk_out;
    logic par_txclk, par_txctl, par_rxclk, par_rxctl;
    logic [3:0] par_txd, par_rxd;
    logic [15:0] ser_cfg_word;
    int miscompares = 0, total_checks = 0, n, m;
    always #12.5 clk = !clk;
    mis_mac_if_select DUT (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .serial_enable_strap_pin(1'b1),
        .parallel_disable_strap_pin(1'b0), .media_speed, .media_link, .media_rx,
        .media_rx_ready, .media_tx, .ser_rx_in, .ser_tx, .ser_cfg_word, .ser_cfg_valid,
        .ser_cfg_ack, .ser_rxclk_out, .par_txclk, .par_txd, .par_txctl, .par_rxclk, .par_rxd,
        .par_rxctl);
    mis_mac_model MAC (.clk, .resetn, .ser_cfg_valid, .ser_cfg_ack, .ser_rx(ser_rx_in), .par_go,
        .ser_tx, .par_txclk, .par_txd, .par_txctl);
    // ****************************************
    // Tasks
    // ****************************************
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task limit(input int k, input int lim);
        if (k >= lim) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        limit(k, 20);
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input string name, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(name, q, exp);
    endtask
    task send(input logic [7:0] b);
        int k;
        media_rx <= {1'b1, 1'b0, b};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (media_rx_ready !== 1'b1 && k < 40);
        media_rx <= '0;
        limit(k, 40);
        n = 0;
        m = 0;
        repeat (150) begin
            @(posedge clk);
            if (ser_tx.valid === 1'b1 && ser_tx.data === b) n++;
            if (media_tx.valid === 1'b1 && media_tx.data === b) m++;
        end
    endtask
    task phase(input logic v);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (par_rxclk !== v && n < 40);
        limit(n, 40);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'hCC, "strap status", 32'h1);
        rd(8'h40, "phy control", 32'h800);
        rd(8'hC8, "parallel control", 32'h80);
        rd(8'h50, "second config", 32'h1);
        rd(8'h08, "unmapped", 32'h0);
        $display("test registers done");
        bus(1'b1, 8'h50, 32'h3);
        n = 0;
        do begin
            bus(1'b0, 8'h44, 32'h0);
            n++;
        end while (q[4] !== 1'b1 && n < 50);
        limit(n, 50);
        chk("serial status", q, 32'h15);
        send(8'h5A);
        chk("repeat count", n, 10);
        chk("echo", m, 1);
        send(mis_pkg::SFD_BYTE);
        chk("delimiter count", n, 1);
        $display("test serial done");
        bus(1'b1, 8'h50, 32'h0);
        media_speed <= 2'h0;
        bus(1'b0, 8'h44, 32'h0);
        chk("forced status", q & 32'hF, 32'h1);
        rd(8'h50, "adapt bit", 32'h0);
        send(8'h33);
        chk("ten meg count", n, 100);
        $display("test forced done");
        bus(1'b1, 8'h40, 32'h0);
        bus(1'b0, 8'h44, 32'h0);
        chk("parallel mode", q & 32'h3, 32'h2);
        par_go <= 1'b1;
        phase(1'b0);
        phase(1'b1);
        phase(1'b0);
        chk("clock half", n, mis_pkg::TEN_HALF);
        n = 0;
        repeat (300) begin
            @(posedge clk);
            if (media_tx.valid === 1'b1) n++;
        end
        chk("bytes from mac", n > 0, 32'h1);
        $display("test parallel done");
        bus(1'b1, 8'hC8, 32'h0);
        bus(1'b0, 8'h44, 32'h0);
        chk("off mode", q & 32'h3, 32'h0);
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (par_rxclk !== 1'b0 || ser_tx.valid !== 1'b0) n++;
        end
        chk("quiet link", n, 0);
        $display("test off done");
        tally_and_finish();
    end
endmodule // mis_mac_if_select_bench
bind mis_mac_if_select mis_chk CHK (.clk, .resetn, .avs_read, .avs_write, .avs_waitrequest,
    .media_speed, .media_rx, .media_rx_ready, .ser_tx, .ser_cfg_word, .ser_cfg_valid,
    .ser_cfg_ack, .ser_rxclk_out, .par_rxclk);
`default_nettype wire
